// *** dv/aph_dev_model.sv ***
`timescale 1ns/1ps
module aph_dev_model (
  input  logic [7:0]                 ad_out,
  input  logic                       ad_oe,
  input  logic                       ale,
  input  logic                       util_write_strobe_n,
  input  logic                       util_read_strobe_n,
  input  logic                       util_cs_n,
  input  logic                       tx_clk,
  input  aph_pkg::aph_utopia_tx_type tx_pins,
  input  logic                       tx_timing_ref_n,
  input  logic                       rx_clk,
  input  logic                       rx_enb_n,
  input  logic                       room,
  input  logic                       send,
  input  logic                       mark,
  output logic [7:0]                 ad_in,
  output logic                       tx_flow,
  output logic [7:0]                 rx_data,
  output logic                       rx_parity,
  output logic                       rx_soc,
  output logic                       rx_flow,
  output logic                       rx_timing_ref_n,
  output logic                       user_latched_out,
  output logic [7:0]                 tx_cnt,
  output logic [7:0]                 tx_bad,
  output logic [7:0]                 tx_ref_cnt,
  output logic                       rx_activity_indicator_n,
  output logic                       tx_activity_indicator_n
);
  logic [7:0] regs [8];
  logic [2:0] addr;
  logic [5:0] rx_k;
  logic [3:0] rx_led_cnt, tx_led_cnt;
  initial begin
    regs = '{default: 8'h00};
    {addr, rx_k, rx_data, rx_soc, tx_cnt, tx_bad, tx_ref_cnt, rx_led_cnt, tx_led_cnt} = '0;
    rx_timing_ref_n = 1'b1;
  end
  always @(negedge ale) addr <= ad_out[2:0];
  always @(posedge util_write_strobe_n) if (!util_cs_n) regs[addr] <= ad_out;
  // released bus shows the inverse, never the last value
  assign ad_in = ad_oe ? ad_out : (!util_read_strobe_n && !util_cs_n) ? regs[addr] : ~regs[addr];
  assign user_latched_out = ~regs[0][7];
  assign tx_flow = room;
  always @(posedge tx_clk) if (!tx_pins.enb_n) begin
    tx_bad <= tx_bad + 8'((tx_pins.data !== 8'h3C) || (tx_pins.soc !== (tx_cnt == 8'h00)));
    tx_cnt <= tx_cnt + 8'h01;
  end
  always @(negedge tx_timing_ref_n) tx_ref_cnt <= tx_ref_cnt + 8'h01;
  // indicators hold low a fixed time after each byte, retriggering
  always @(posedge rx_clk) rx_led_cnt <= (!rx_enb_n && rx_flow) ? 4'hF : rx_led_cnt - 4'(rx_led_cnt != 4'h0);
  always @(posedge tx_clk) tx_led_cnt <= !tx_pins.enb_n ? 4'hF : tx_led_cnt - 4'(tx_led_cnt != 4'h0);
  assign rx_activity_indicator_n = rx_led_cnt == 4'h0;
  assign tx_activity_indicator_n = tx_led_cnt == 4'h0;
  assign rx_flow = send && (rx_k < 6'd53);
  always @(posedge rx_clk) begin
    if (!rx_enb_n && rx_flow) begin
      rx_data <= 8'h5A ^ {2'h0, rx_k};
      rx_soc <= (rx_k == 6'd0);
      rx_k <= rx_k + 6'd1;
    end else begin
      rx_data <= ~rx_data;
      rx_soc <= 1'b0;
    end
  end
  assign rx_parity = ~^rx_data;
  always @(posedge mark) begin
    rx_timing_ref_n = 1'b0;
    repeat (1 << regs[3][4:3]) @(posedge rx_clk);
    rx_timing_ref_n = 1'b1;
  end
endmodule : aph_dev_model

// *** dv/aph_host_chk.sv ***
`timescale 1ns/1ps
module aph_host_chk (
  input logic                       clk,
  input logic                       reset_n,
  input logic                       ub_req,
  input logic                       ub_busy,
  input logic                       ub_done,
  input logic [7:0]                 ad_out,
  input logic                       ad_oe,
  input logic                       ale,
  input logic                       util_write_strobe_n,
  input logic                       util_read_strobe_n,
  input logic                       util_cs_n,
  input logic                       tx_clk,
  input logic                       rx_clk,
  input aph_pkg::aph_utopia_tx_type tx_pins,
  input logic                       tx_timing_ref_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  addr_latch_a: assert property ($fell(ale) |-> ad_oe && $stable(ad_out) && !util_cs_n)
    else $error("address not held at latch");
  write_low_a: assert property (!util_write_strobe_n |-> !util_cs_n && ad_oe && util_read_strobe_n)
    else $error("write strobe outside access");
  read_low_a: assert property (!util_read_strobe_n |-> !util_cs_n && !ad_oe)
    else $error("read strobe while driving");
  ub_answer_a: assert property (ub_req && !ub_busy |-> ##11 ub_done)
    else $error("access not done in time");
  tx_odd_par_a: assert property (!tx_pins.enb_n |-> (^tx_pins.data) != tx_pins.parity)
    else $error("tx parity not odd");
  tx_soc_enb_a: assert property (tx_pins.soc |-> !tx_pins.enb_n)
    else $error("soc without enable");
  tx_clk_half_a: assert property ($rose(tx_clk) |=> tx_clk [*3] ##1 !tx_clk)
    else $error("tx link clock high time");
  rx_clk_half_a: assert property ($fell(rx_clk) |=> !rx_clk [*3] ##1 rx_clk)
    else $error("rx link clock low time");
  tx_ref_len_a: assert property ($fell(tx_timing_ref_n) |-> !tx_timing_ref_n [*4] ##1 tx_timing_ref_n)
    else $error("tx reference length");
  cover property ($fell(ale));
  cover property (tx_pins.soc);
  cover property ($fell(tx_timing_ref_n));
endmodule : aph_host_chk
bind aph_host aph_host_chk u_chk (.*);

// *** dv/tb.sv ***
`timescale 1ns/1ps
`include "aph_consts.svh"
module tb;
  logic clk, reset_n, ub_req, ub_req_read, ub_busy, ub_done, tx_cell_valid, tx_cell_ready, tx_cell_done;
  logic rx_byte_valid, rx_byte_soc, rx_parity_err, rx_timing_ref_seen, tx_timing_req, ad_oe, ale, util_cs_n;
  logic util_write_strobe_n, util_read_strobe_n, tx_clk, tx_flow, tx_timing_ref_n, rx_clk, rx_enb_n;
  logic rx_parity, rx_soc, rx_flow, rx_timing_ref_n, room, send, mark, user_latched_out;
  logic [7:0] ub_req_addr, ub_req_wdata, ub_rdata, tx_cell_byte, rx_byte, ad_in, ad_out, rx_data;
  logic [7:0] tx_cnt, tx_bad, tx_ref_cnt;
  logic rx_activity_indicator_n, tx_activity_indicator_n;
  aph_pkg::aph_utopia_tx_type tx_pins;
  int fail_count, cmp_count;
  wire [3:0] flags = {ub_done, tx_cell_done, rx_timing_ref_seen, rx_byte_valid};
  aph_host u_dut (.*);
  aph_dev_model u_dev (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_for(int b, int n);
    for (int i = 0; i < n && flags[b] !== 1'b1; i++) @(negedge clk);
    if (flags[b] !== 1'b1) begin
      fail_count++;
      $display("wrong value timeout flag %0d expected 1 seen 0", b);
      give_verdict();
    end
  endtask : wait_for
  task automatic ub_access(logic rd, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    ub_req <= 1'b1;
    ub_req_read <= rd;
    ub_req_addr <= a;
    ub_req_wdata <= d;
    @(posedge clk);
    ub_req <= 1'b0;
    wait_for(3, 20);
  endtask : ub_access
  task automatic t_util;
    chk("indicators idle", 8'h03, {6'h0, rx_activity_indicator_n, tx_activity_indicator_n});
    ub_access(1'b0, `APH_REG0_ADDR, 8'h80);
    chk("user out", 8'h00, {7'h0, user_latched_out});
    ub_access(1'b1, `APH_REG0_ADDR, 8'h00);
    chk("reg0 read", 8'h80, ub_rdata);
    ub_access(1'b0, 8'h05, 8'h3C);
    ub_access(1'b1, 8'h05, 8'h00);
    chk("reg5 read", 8'h3C, ub_rdata);
    ub_access(1'b0, `APH_REG0_ADDR, 8'h7F);
    chk("user out", 8'h01, {7'h0, user_latched_out});
    $display("test util done");
  endtask : t_util
  task automatic t_tx;
    @(posedge clk);
    room <= 1'b0;
    repeat (4) @(posedge clk);
    tx_cell_byte <= 8'h3C;
    tx_cell_valid <= 1'b1;
    repeat (40) @(posedge clk);
    chk("tx while full", 8'h00, tx_cnt);
    chk("tx ready while full", 8'h00, {7'h0, tx_cell_ready});
    room <= 1'b1;
    repeat (40) @(posedge clk);
    chk("tx ready in cell", 8'h01, {7'h0, tx_cell_ready});
    chk("tx indicator", 8'h00, {7'h0, tx_activity_indicator_n});
    wait_for(2, 1000);
    chk("tx ready after cell", 8'h00, {7'h0, tx_cell_ready});
    @(posedge clk);
    tx_cell_valid <= 1'b0;
    repeat (16) @(posedge clk);
    chk("tx bytes", 8'(`APH_CELL_BYTES), tx_cnt);
    chk("tx bad", 8'h00, tx_bad);
    $display("test tx done");
  endtask : t_tx
  task automatic t_rx;
    @(posedge clk);
    send <= 1'b1;
    for (int k = 0; k < 53; k++) begin
      wait_for(0, 1000);
      chk("rx byte", 8'h5A ^ k[7:0], rx_byte);
      chk("rx soc", {7'h0, k == 0}, {7'h0, rx_byte_soc});
      chk("rx parity", 8'h00, {7'h0, rx_parity_err});
      if (k == 20) chk("rx indicator", 8'h00, {7'h0, rx_activity_indicator_n});
      @(negedge clk);
    end
    $display("test rx done");
  endtask : t_rx
  task automatic t_ref;
    for (int c = 0; c < 4; c++) begin
      ub_access(1'b0, 8'h03, 8'(c << 3));
      @(posedge clk);
      mark <= 1'b1;
      wait_for(1, 400);
      chk("rx ref seen", 8'h01, {7'h0, flags[1]});
      @(negedge clk);
      chk("rx ref one pulse", 8'h00, {7'h0, flags[1]});
      @(posedge clk);
      mark <= 1'b0;
      repeat (150) @(posedge clk);
    end
    tx_timing_req <= 1'b1;
    @(posedge clk);
    tx_timing_req <= 1'b0;
    repeat (10) @(posedge clk);
    chk("tx ref", 8'h01, tx_ref_cnt);
    $display("test ref done");
  endtask : t_ref
  initial begin
    {reset_n, ub_req, ub_req_read, tx_cell_valid, tx_timing_req, send, mark} = '0;
    {ub_req_addr, ub_req_wdata, tx_cell_byte} = '0;
    room = 1'b1;
    fail_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_util();
    t_tx();
    t_rx();
    t_ref();
    give_verdict();
  end
endmodule : tb

// *** include/aph_consts.svh ***
`ifndef APH_CONSTS_SVH
`define APH_CONSTS_SVH
`define APH_CELL_BYTES     6'd53
`define APH_LINK_DIV_HALF  4'd4
`define APH_UB_PHASE_CYC   3'd3
`define APH_REF_LOW_CYC    4'd4
`define APH_REG0_ADDR      8'h00
`define APH_USER_LATCHED_OUT_BIT       3'd7
`endif

// *** include/aph_pkg.sv ***
package aph_pkg;
  typedef enum logic [2:0] {
    UB_IDLE  = 3'b000,
    UB_ALE   = 3'b001,
    UB_LATCH = 3'b010,
    UB_STRB  = 3'b011,
    UB_DONE  = 3'b100
  } aph_ub_state_type;

  typedef struct packed {
    logic [7:0] ad_out;
    logic       ad_oe;
    logic       ale;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic       cs_n;
  } aph_ub_pins_type;

  typedef struct packed {
    aph_ub_state_type state;
    logic [2:0]       cnt;
    logic [7:0]       addr;
    logic [7:0]       wdata;
    logic             is_read;
    logic [7:0]       rdata;
    logic             done;
    logic             busy;
    aph_ub_pins_type  pins;
  } aph_ub_state_all_type;

  typedef struct packed {
    logic [7:0] data;
    logic       parity;
    logic       soc;
    logic       enb_n;
  } aph_utopia_tx_type;
endpackage : aph_pkg

// *** rtl/aph_host.sv ***
// Functional notes
// - address stable across address latch falling edge
// - write strobe is active low
// - read strobe low, device drives data
// - line reference oscillator 32 MHz 100ppm
// - receive signals synchronous to host rx clock
// - host drives receive enable low to read
// - host marks first transmit byte with soc
// - transmit enable low with valid byte
// - transmit signals synchronous to host tx clock
// - host drives transmit parity over data
// - transmit parity never left floating
// - falling transmit reference inserts marker
// - each unit is a 53-byte cell
`timescale 1ns/1ps
`include "aph_consts.svh"
module aph_host #(
  parameter bit CELL_MODE = 1'b1
) (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // user side: one register access
  input  wire logic                   ub_req,
  input  wire logic                   ub_req_read,
  input  wire logic [7:0]             ub_req_addr,
  input  wire logic [7:0]             ub_req_wdata,
  output logic                        ub_busy,
  output logic                        ub_done,
  output logic [7:0]                  ub_rdata,
  // user side: cells
  input  wire logic                   tx_cell_valid,
  input  wire logic [7:0]             tx_cell_byte,
  output logic                        tx_cell_ready,
  output logic                        tx_cell_done,
  output logic [7:0]                  rx_byte,
  output logic                        rx_byte_valid,
  output logic                        rx_byte_soc,
  output logic                        rx_parity_err,
  output logic                        rx_timing_ref_seen,
  input  wire logic                   tx_timing_req,
  // utility bus pins
  input  wire logic [7:0]             ad_in,
  output logic [7:0]                  ad_out,
  output logic                        ad_oe,
  output logic                        ale,
  output logic                        util_write_strobe_n,
  output logic                        util_read_strobe_n,
  output logic                        util_cs_n,
  // utopia transmit pins
  output logic                        tx_clk,
  output aph_pkg::aph_utopia_tx_type  tx_pins,
  input  wire logic                   tx_flow,
  output logic                        tx_timing_ref_n,
  // utopia receive pins
  output logic                        rx_clk,
  output logic                        rx_enb_n,
  input  wire logic [7:0]             rx_data,
  input  wire logic                   rx_parity,
  input  wire logic                   rx_soc,
  input  wire logic                   rx_flow,
  input  wire logic                   rx_timing_ref_n
);
  // flow control below serves whole cells only
  if (CELL_MODE != 1'b1) begin : g_mode_chk
    $error("CELL_MODE must be 1: only cell mode flow is built");
  end

  typedef struct packed {
    logic [3:0]                 div;
    logic                       lclk;
    logic                       tx_ref_n;
    logic [3:0]                 ref_cnt;
    logic [5:0]                 tx_idx;
    logic                       tx_active;
    logic                       tx_done;
    aph_pkg::aph_utopia_tx_type tx;
    logic [5:0]                 rx_left;
    logic                       rx_pend;
    logic                       rx_enb_n;
    logic [7:0]                 rx_byte;
    logic                       rx_valid;
    logic                       rx_soc;
    logic                       rx_perr;
    logic                       rx_ref_d;
    logic                       rx_ref_seen;
    logic [12:0]                rx_sync1;
    logic [12:0]                rx_sync2;
    logic [7:0]                 ad_sync1;
    logic [7:0]                 ad_sync2;
  } aph_host_state_type;

  aph_host_state_type s_reg, s_next;
  aph_pkg::aph_ub_pins_type ub_pins;

  aph_util_master u_util (
    .clk       (clk),
    .reset_n   (reset_n),
    .req       (ub_req),
    .req_read  (ub_req_read),
    .req_addr  (ub_req_addr),
    .req_wdata (ub_req_wdata),
    .ad_in     (s_reg.ad_sync2),
    .pins      (ub_pins),
    .busy      (ub_busy),
    .done      (ub_done),
    .rdata     (ub_rdata)
  );

  logic rise;
  logic fall;
  logic rx_flow_s;
  logic rx_ref_s;
  logic tx_flow_ok;
  logic rx_flow_ok;

  always_comb begin
    s_next          = s_reg;
    s_next.rx_valid = 1'b0;
    s_next.tx_done  = 1'b0;
    s_next.rx_ref_seen = 1'b0;
    // link clock from divider; both paths share it
    s_next.rx_sync1 = {tx_flow, rx_flow, rx_timing_ref_n, rx_soc, rx_parity, rx_data};
    s_next.rx_sync2 = s_reg.rx_sync1;
    // two flops on ad_in use up two of the three strobe cycles
    s_next.ad_sync1 = ad_in;
    s_next.ad_sync2 = s_reg.ad_sync1;
    rise = 1'b0;
    fall = 1'b0;
    if (s_reg.div == `APH_LINK_DIV_HALF - 4'd1) begin
      s_next.div  = 4'd0;
      s_next.lclk = !s_reg.lclk;
      rise = !s_reg.lclk;
      fall = s_reg.lclk;
    end else begin
      s_next.div = s_reg.div + 4'd1;
    end
    rx_flow_s  = s_reg.rx_sync2[11];
    rx_ref_s   = s_reg.rx_sync2[10];
    tx_flow_ok = s_reg.rx_sync2[12]; // cell mode only: high means room
    rx_flow_ok = rx_flow_s; // high = data/cell
    // transmit timing reference: hold low a few cycles per request
    if (tx_timing_req && s_reg.tx_ref_n) begin
      s_next.tx_ref_n = 1'b0;
      s_next.ref_cnt = `APH_REF_LOW_CYC;
    end else if (!s_reg.tx_ref_n) begin
      s_next.ref_cnt = s_reg.ref_cnt - 4'd1;
      if (s_reg.ref_cnt == 4'd1) s_next.tx_ref_n = 1'b1;
    end
    if (fall) begin
      // drive on falling edge, device samples on rising
      if (!s_reg.tx_active && tx_cell_valid && tx_flow_ok) begin
        s_next.tx_active = 1'b1;
        s_next.tx_idx    = 6'd0;
      end
      if ((s_reg.tx_active || (tx_cell_valid && tx_flow_ok)) && tx_cell_valid) begin
        s_next.tx.data   = tx_cell_byte;
        s_next.tx.parity = ~^tx_cell_byte;
        s_next.tx.soc    = !s_reg.tx_active;
        s_next.tx.enb_n  = 1'b0;
        if (s_reg.tx_active) begin
          s_next.tx_idx = s_reg.tx_idx + 6'd1;
          if (s_reg.tx_idx == `APH_CELL_BYTES - 6'd2) begin
            s_next.tx_active = 1'b0;
            s_next.tx_done   = 1'b1;
          end
        end
      end else begin
        s_next.tx.enb_n = 1'b1;
        s_next.tx.soc   = 1'b0;
      end
      // one request per link cycle until the whole cell is asked for
      if (s_reg.rx_left == 6'd0 && rx_flow_ok) begin
        s_next.rx_left  = `APH_CELL_BYTES;
        s_next.rx_enb_n = 1'b0;
      end else begin
        s_next.rx_enb_n = s_reg.rx_left == 6'd0;
      end
    end
    if (rise) begin
      // device answers at the edge that sees enable; byte taken one link cycle later
      s_next.rx_pend = !s_reg.rx_enb_n;
      if (!s_reg.rx_enb_n) s_next.rx_left = s_reg.rx_left - 6'd1;
      if (s_reg.rx_pend) begin
        s_next.rx_byte  = s_reg.rx_sync2[7:0];
        s_next.rx_valid = 1'b1;
        s_next.rx_soc   = s_reg.rx_sync2[9];
        s_next.rx_perr  = (^s_reg.rx_sync2[8:0]) != 1'b1;
      end
    end
    s_next.rx_ref_d = rx_ref_s;
    if (s_reg.rx_ref_d && !rx_ref_s) s_next.rx_ref_seen = 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg          <= '0;
      s_reg.tx.enb_n <= 1'b1;
      s_reg.tx.parity <= 1'b1;
      s_reg.rx_enb_n <= 1'b1;
      s_reg.rx_ref_d <= 1'b1;
      s_reg.tx_ref_n <= 1'b1;
      s_reg.rx_sync1 <= 13'h1FFF;
      s_reg.rx_sync2 <= 13'h1FFF;
    end else begin
      s_reg <= s_next;
    end
  end

  assign ad_out              = ub_pins.ad_out;
  assign ad_oe               = ub_pins.ad_oe;
  assign ale                 = ub_pins.ale;
  assign util_write_strobe_n = ub_pins.write_strobe_n;
  assign util_read_strobe_n  = ub_pins.read_strobe_n;
  assign util_cs_n           = ub_pins.cs_n;
  assign tx_clk              = s_reg.lclk;
  assign rx_clk              = s_reg.lclk;
  assign tx_pins             = s_reg.tx;
  assign tx_timing_ref_n     = s_reg.tx_ref_n;
  assign rx_enb_n            = s_reg.rx_enb_n;
  assign tx_cell_ready       = s_reg.tx_active;
  assign tx_cell_done        = s_reg.tx_done;
  assign rx_byte             = s_reg.rx_byte;
  assign rx_byte_valid       = s_reg.rx_valid;
  assign rx_byte_soc         = s_reg.rx_soc;
  assign rx_parity_err       = s_reg.rx_perr;
  assign rx_timing_ref_seen  = s_reg.rx_ref_seen;
endmodule : aph_host

// *** rtl/aph_util_master.sv ***
`timescale 1ns/1ps
`include "aph_consts.svh"
module aph_util_master (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  req,
  input  wire logic                  req_read,
  input  wire logic [7:0]            req_addr,
  input  wire logic [7:0]            req_wdata,
  input  wire logic [7:0]            ad_in,
  output aph_pkg::aph_ub_pins_type   pins,
  output logic                       busy,
  output logic                       done,
  output logic [7:0]                 rdata
);
  aph_pkg::aph_ub_state_all_type st_reg, st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    case (st_reg.state)
      aph_pkg::UB_IDLE: begin
        if (req) begin
          st_next.addr    = req_addr;
          st_next.wdata   = req_wdata;
          st_next.is_read = req_read;
          st_next.busy    = 1'b1;
          st_next.pins.cs_n   = 1'b0;
          st_next.pins.ale    = 1'b1;
          st_next.pins.ad_out = req_addr;
          st_next.pins.ad_oe  = 1'b1;
          st_next.cnt   = `APH_UB_PHASE_CYC;
          st_next.state = aph_pkg::UB_ALE;
        end
      end
      aph_pkg::UB_ALE: begin
        // address held stable across the falling edge
        st_next.cnt = st_reg.cnt - 3'd1;
        if (st_reg.cnt == 3'd1) begin
          st_next.pins.ale = 1'b0;
          st_next.cnt   = `APH_UB_PHASE_CYC;
          st_next.state = aph_pkg::UB_LATCH;
        end
      end
      aph_pkg::UB_LATCH: begin
        st_next.cnt = st_reg.cnt - 3'd1;
        if (st_reg.cnt == 3'd1) begin
          st_next.pins.ad_out = st_reg.wdata;
          st_next.pins.ad_oe  = !st_reg.is_read;
          st_next.pins.read_strobe_n  = !st_reg.is_read;
          st_next.pins.write_strobe_n = st_reg.is_read;
          st_next.cnt   = `APH_UB_PHASE_CYC;
          st_next.state = aph_pkg::UB_STRB;
        end
      end
      aph_pkg::UB_STRB: begin
        st_next.cnt = st_reg.cnt - 3'd1;
        if (st_reg.cnt == 3'd1) begin
          if (st_reg.is_read) begin
            st_next.rdata = ad_in;
          end
          st_next.pins.read_strobe_n  = 1'b1;
          st_next.pins.write_strobe_n = 1'b1;
          st_next.state = aph_pkg::UB_DONE;
        end
      end
      aph_pkg::UB_DONE: begin
        st_next.pins.ad_oe = 1'b0;
        st_next.pins.cs_n  = 1'b1;
        st_next.done  = 1'b1;
        st_next.busy  = 1'b0;
        st_next.state = aph_pkg::UB_IDLE;
      end
      default: st_next.state = aph_pkg::UB_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg       <= '0;
      st_reg.pins  <= '{ad_out: 8'h00, ad_oe: 1'b0, ale: 1'b0, write_strobe_n: 1'b1,
                        read_strobe_n: 1'b1, cs_n: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins  = st_reg.pins;
  assign busy  = st_reg.busy;
  assign done  = st_reg.done;
  assign rdata = st_reg.rdata;
endmodule : aph_util_master
